// ===== inc/attr_packet_regs.svh
// register offsets, field positions, reset values and counts of the attribute inserter
`ifndef ATTR_PACKET_REGS_SVH
`define ATTR_PACKET_REGS_SVH

`define AP_ADDR_W          8
`define AP_OFS_HDR         8'h00
`define AP_OFS_PAY_FIRST   8'h04
`define AP_OFS_PAY_LAST    8'h20
`define AP_OFS_DAC         8'h24
`define AP_OFS_EXT         8'h28
`define AP_OFS_CLKCTL      8'h2C
`define AP_OFS_FULLSW      8'h30
`define AP_OFS_STATUS      8'h34

`define AP_ENABLE_BIT      7
`define AP_HDR_MSB         5
`define AP_HDR_W           6
`define AP_PAY_W           16
`define AP_PAY_WORDS       8
`define AP_PKT_LEN         8'h86
`define AP_LOAD_LAST       8'h08

`define AP_OFF_MSB         15
`define AP_OFF_LSB         10
`define AP_GAIN_MSB        9
`define AP_GAIN_FRAC       9
`define AP_FULL_MSB        6
`define AP_FULL_LSB        4
`define AP_ENCODER_CLOCK_ENABLE_BIT      0
`define AP_EXT_W           12

`define AP_RST_HDR         8'h00
`define AP_RST_DAC         16'hFE00
`define AP_RST_EXT         12'h000
`define AP_RST_FULL        3'h0
`define AP_RST_CLKEN       1'h0

`define AP_LINE_525P       11'h028
`define AP_LINE_1080I_A    11'h012
`define AP_LINE_1080I_B    11'h245
`define AP_LINE_720P       11'h017
`define AP_DAC_MAX         12'h3FF

`endif

// ===== inc/attr_packet_pkg.sv
// types shared by the attribute packet inserter
package attr_packet_pkg;

	typedef enum logic [1:0] {
		STD_OTHER,
		STD_525P,
		STD_1080I,
		STD_720P
	} video_std_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LOAD,
		ST_SEND
	} ins_state_t;

	typedef struct packed {
		logic valid;
		logic first;
		logic data;
	} pkt_bit_t;

	typedef logic [2:0][9:0] dac_trio_t;

endpackage : attr_packet_pkg

// ===== core/attr_payload_mem.sv
// small payload word store with two registered read ports
`timescale 1ns/1ps
`include "attr_packet_regs.svh"

module attr_payload_mem #(
	parameter int WIDTH = `AP_PAY_W,
	parameter int DEPTH = `AP_PAY_WORDS,
	parameter int AW    = 3
) (
	input  wire logic             i_clk,
	input  wire logic             i_reset,
	input  wire logic             i_we,
	input  wire logic [AW-1:0]    i_waddr,
	input  wire logic [WIDTH-1:0] i_wdata,
	input  wire logic             i_re_a,
	input  wire logic [AW-1:0]    i_raddr_a,
	output logic      [WIDTH-1:0] o_rdata_a,
	input  wire logic             i_re_b,
	input  wire logic [AW-1:0]    i_raddr_b,
	output logic      [WIDTH-1:0] o_rdata_b
);

	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int k = 0; k < DEPTH; k++) begin
				mem_q[k] <= '0;
			end
		end else if (i_we) begin
			mem_q[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rdata_a <= '0;
			o_rdata_b <= '0;
		end else begin
			if (i_re_a) begin
				o_rdata_a <= mem_q[i_raddr_a];
			end
			if (i_re_b) begin
				o_rdata_b <= mem_q[i_raddr_b];
			end
		end
	end

endmodule : attr_payload_mem

// ===== core/attr_packet_inserter.sv
// video attribute packet inserter with dac scaling and hd line extension
// Contract
// - insert on lines 40, 18/581, 23
// - only 525P/1080I/720P, never when disabled
// - header bits from first register bits 5-0
// - payload from eight 16-bit words, ascending
// - offset only in full-range mode
// - gain is 1.9 unsigned, full-range only
// - stretch hd line by extension count
// - extension only in 1080i and 720p
// - per-dac full-swing select enables scaling
// - encoder runs only with clock enable set
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "attr_packet_regs.svh"

module attr_packet_inserter (
	input  wire logic                        i_clk,
	input  wire logic                        i_reset,
	input  wire logic [`AP_ADDR_W-1:0]       i_addr,
	input  wire logic [31:0]                 i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic      [31:0]                 o_rdata,
	input  attr_packet_pkg::video_std_t      i_std,
	input  wire logic                        i_line_start,
	input  wire logic [10:0]                 i_line_num,
	input  wire logic                        i_line_end,
	output logic                             o_line_stall,
	input  attr_packet_pkg::dac_trio_t       i_dac,
	output attr_packet_pkg::dac_trio_t       o_dac,
	output attr_packet_pkg::pkt_bit_t        o_pkt
);

	logic [7:0]             hdr_q;
	logic [15:0]            dac_q;
	logic [`AP_EXT_W-1:0]   ext_q;
	logic [2:0]             full_q;
	logic                   clken_q;
	logic [31:0]            rdata_q;
	logic                   rsel_mem_q;
	logic [`AP_EXT_W-1:0]   ext_cnt_q;
	attr_packet_pkg::ins_state_t st_q;
	logic [7:0]             cnt_q;
	logic [133:0]           pkt_q;
	logic [15:0]            mem_a;
	logic [15:0]            mem_b;

	// register decode
	wire hit_hdr  = i_addr == `AP_OFS_HDR;
	wire hit_dac  = i_addr == `AP_OFS_DAC;
	wire hit_ext  = i_addr == `AP_OFS_EXT;
	wire hit_clk  = i_addr == `AP_OFS_CLKCTL;
	wire hit_full = i_addr == `AP_OFS_FULLSW;
	wire hit_stat = i_addr == `AP_OFS_STATUS;
	wire hit_pay  = (i_addr >= `AP_OFS_PAY_FIRST) && (i_addr <= `AP_OFS_PAY_LAST)
		&& (i_addr[1:0] == 2'h0);
	wire [7:0] pay_off = i_addr - `AP_OFS_PAY_FIRST;
	wire [2:0] pay_idx = pay_off[4:2];

	// encoder clock gate
	// enable gating
	wire run = clken_q;

	wire [31:0] status_w = {29'h0, ext_cnt_q != '0, st_q != attr_packet_pkg::ST_IDLE, clken_q};

	wire [31:0] rd_mux =
		hit_hdr  ? {24'h0, hdr_q} :
		hit_dac  ? {16'h0, dac_q} :
		hit_ext  ? {20'h0, ext_q} :
		hit_clk  ? {31'h0, clken_q} :
		hit_full ? {25'h0, full_q, 4'h0} :
		hit_stat ? status_w : 32'h0;

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			hdr_q   <= `AP_RST_HDR;
			dac_q   <= `AP_RST_DAC;
			ext_q   <= `AP_RST_EXT;
			full_q  <= `AP_RST_FULL;
			clken_q <= `AP_RST_CLKEN;
		end else if (i_wr) begin
			if (hit_hdr) hdr_q <= {i_wdata[`AP_ENABLE_BIT], 1'b0, i_wdata[`AP_HDR_MSB:0]};
			if (hit_dac) dac_q <= i_wdata[15:0];
			if (hit_ext) ext_q <= i_wdata[`AP_EXT_W-1:0];
			if (hit_full) full_q <= i_wdata[`AP_FULL_MSB:`AP_FULL_LSB];
			if (hit_clk) clken_q <= i_wdata[`AP_ENCODER_CLOCK_ENABLE_BIT];
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			rdata_q    <= 32'h0;
			rsel_mem_q <= 1'b0;
		end else begin
			rdata_q    <= i_rd ? rd_mux : 32'h0;
			rsel_mem_q <= i_rd && hit_pay;
		end
	end

	assign o_rdata = rsel_mem_q ? {16'h0, mem_a} : rdata_q;

	// insertion line match
	// line selection
	wire line_hit =
		((i_std == attr_packet_pkg::STD_525P) && (i_line_num == `AP_LINE_525P)) ||
		((i_std == attr_packet_pkg::STD_1080I) &&
			((i_line_num == `AP_LINE_1080I_A) || (i_line_num == `AP_LINE_1080I_B))) ||
		((i_std == attr_packet_pkg::STD_720P) && (i_line_num == `AP_LINE_720P));

	wire pkt_start = run && i_line_start && hdr_q[`AP_ENABLE_BIT] && line_hit
		&& (st_q == attr_packet_pkg::ST_IDLE);

	wire load_rd  = run && (st_q == attr_packet_pkg::ST_LOAD) && (cnt_q < `AP_LOAD_LAST);
	wire load_cap = run && (st_q == attr_packet_pkg::ST_LOAD) && (cnt_q != 8'h00);
	wire send_end = run && (st_q == attr_packet_pkg::ST_SEND) && (cnt_q == `AP_PKT_LEN - 8'h01);

	// payload words are fetched one a cycle during load; a write landing in
	// those nine cycles may still be seen, so software writes between lines
	attr_payload_mem #(
		.WIDTH (`AP_PAY_W),
		.DEPTH (`AP_PAY_WORDS),
		.AW    (3)
	) u_mem (
		.i_clk     (i_clk),
		.i_reset   (i_reset),
		.i_we      (i_wr && hit_pay),
		.i_waddr   (pay_idx),
		.i_wdata   (i_wdata[15:0]),
		.i_re_a    (i_rd && hit_pay),
		.i_raddr_a (pay_idx),
		.o_rdata_a (mem_a),
		.i_re_b    (load_rd),
		.i_raddr_b (cnt_q[2:0]),
		.o_rdata_b (mem_b)
	);

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			st_q  <= attr_packet_pkg::ST_IDLE;
			cnt_q <= 8'h00;
		end else if (run) begin
			case (st_q)
				attr_packet_pkg::ST_IDLE: begin
					cnt_q <= 8'h00;
					if (pkt_start) st_q <= attr_packet_pkg::ST_LOAD;
				end
				attr_packet_pkg::ST_LOAD: begin
					if (cnt_q == `AP_LOAD_LAST) begin
						st_q  <= attr_packet_pkg::ST_SEND;
						cnt_q <= 8'h00;
					end else begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				attr_packet_pkg::ST_SEND: begin
					cnt_q <= cnt_q + 8'h01;
					if (send_end) st_q <= attr_packet_pkg::ST_IDLE;
				end
				default: st_q <= attr_packet_pkg::ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			pkt_q <= '0;
		end else if (pkt_start) begin
			pkt_q[`AP_HDR_W-1:0] <= hdr_q[`AP_HDR_MSB:0];
		end else if (load_cap) begin
			pkt_q <= {mem_b, pkt_q[133:22], pkt_q[5:0]};
		end else if (run && (st_q == attr_packet_pkg::ST_SEND)) begin
			pkt_q <= {1'b0, pkt_q[133:1]};
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_pkt <= '0;
		end else if (run) begin
			o_pkt.valid <= st_q == attr_packet_pkg::ST_SEND;
			o_pkt.first <= (st_q == attr_packet_pkg::ST_SEND) && (cnt_q == 8'h00);
			o_pkt.data  <= (st_q == attr_packet_pkg::ST_SEND) && pkt_q[0];
		end
	end

	// hd line extension
	// hd standards only
	wire hd_std = (i_std == attr_packet_pkg::STD_1080I) || (i_std == attr_packet_pkg::STD_720P);

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			ext_cnt_q <= '0;
		end else if (run) begin
			if (i_line_end && hd_std && (ext_cnt_q == '0)) begin
				ext_cnt_q <= ext_q;
			end else if (ext_cnt_q != '0) begin
				ext_cnt_q <= ext_cnt_q - `AP_EXT_W'(1);
			end
		end
	end

	assign o_line_stall = ext_cnt_q != '0;

	// dac gain and offset, one lane per converter
	wire [5:0] dac_off  = dac_q[`AP_OFF_MSB:`AP_OFF_LSB];
	wire [9:0] dac_gain = dac_q[`AP_GAIN_MSB:0];

	wire attr_packet_pkg::dac_trio_t dac_d;

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_dac
			wire [19:0] prod   = i_dac[g] * dac_gain;
			wire [11:0] summed = {1'b0, prod[19:`AP_GAIN_FRAC]} + {6'h00, dac_off};
			// saturate, a gain near two would otherwise wrap
			wire [9:0]  scaled = (summed > `AP_DAC_MAX) ? 10'h3FF : summed[9:0];

			assign dac_d[g] = full_q[g] ? scaled : i_dac[g];
		end
	endgenerate

	// one process owns the whole trio, since all three lanes share the one variable o_dac
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_dac <= '0;
		end else if (run) begin
			o_dac <= dac_d;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	start_gate_a: assert property (st_q == attr_packet_pkg::ST_IDLE
		&& !(hdr_q[`AP_ENABLE_BIT] && line_hit) |=> st_q == attr_packet_pkg::ST_IDLE)
		else $error("packet started without enable or standard");

	line_start_a: assert property (run && i_line_start && hdr_q[`AP_ENABLE_BIT]
		&& line_hit && st_q == attr_packet_pkg::ST_IDLE |=> st_q == attr_packet_pkg::ST_LOAD)
		else $error("insertion line missed");

	header_snap_a: assert property (pkt_start |=> pkt_q[5:0] == $past(hdr_q[5:0]))
		else $error("header not captured");

	word_order_a: assert property (load_cap && cnt_q == 8'h01 |=>
		pkt_q[133:118] == $past(mem_b))
		else $error("payload word not shifted in");

	send_order_a: assert property ($rose(o_pkt.valid) |-> o_pkt.first ##1 !o_pkt.first)
		else $error("first bit marker wrong");

	dac_plain_a: assert property (run && !full_q[0] |=> o_dac[0] == $past(i_dac[0]))
		else $error("normal dac output altered");

	dac_offset_a: assert property (run && full_q[2] && dac_gain == 10'h000 |=>
		o_dac[2] == {4'h0, $past(dac_off)})
		else $error("dac offset not applied");

	dac_unity_a: assert property (run && full_q[1] && dac_gain == 10'h200
		&& dac_off == 6'h00 |=> o_dac[1] == $past(i_dac[1]))
		else $error("unity gain not transparent");

	ext_load_a: assert property (run && i_line_end && hd_std && ext_cnt_q == '0 |=>
		ext_cnt_q == $past(ext_q))
		else $error("extension count not loaded");

	ext_ignore_a: assert property (i_line_end && !hd_std && ext_cnt_q == '0 |=>
		ext_cnt_q == '0)
		else $error("extension outside hd timing");

	clk_gate_a: assert property (!run |=> $stable(st_q) && $stable(ext_cnt_q)
		&& $stable(o_dac))
		else $error("encoder moved while gated");

	cov_insert_c: cover property (pkt_start ##[1:20] o_pkt.first);
	cov_stall_c: cover property (run && i_line_end && hd_std && ext_q != '0);
	cov_full_c: cover property (run && full_q == 3'h7);

endmodule : attr_packet_inserter

// ===== tb/video_sink_model.sv
// line timing source and packet sink facing the inserter
`timescale 1ns/1ps

module video_sink_model (
	input  wire logic                   i_clk,
	input  attr_packet_pkg::pkt_bit_t   i_pkt,
	output attr_packet_pkg::video_std_t o_std,
	output logic                        o_line_start,
	output logic [10:0]                 o_line_num,
	output logic                        o_line_end
);
	logic [133:0] bits_q = '0;
	logic [7:0]   cnt_q  = 8'h00;
	logic [7:0]   age_q  = 8'h00;
	logic [7:0]   lat_q  = 8'h00;
	int           n_pkts = 0;

	initial begin
		o_std = attr_packet_pkg::STD_OTHER;
		o_line_start = 1'b0;
		o_line_num = 11'h000;
		o_line_end = 1'b0;
	end

	always @(posedge i_clk) begin
		age_q <= o_line_start ? 8'h00 : age_q + 8'h01;
		if (i_pkt.valid && i_pkt.first) begin
			lat_q <= age_q;
			cnt_q <= 8'h01;
			bits_q[0] <= i_pkt.data;
			n_pkts++;
		end else if (i_pkt.valid) begin
			bits_q[cnt_q] <= i_pkt.data;
			cnt_q <= cnt_q + 8'h01;
		end
	end

	task automatic send_line(input attr_packet_pkg::video_std_t s, input logic [10:0] n);
		@(posedge i_clk);
		o_std <= s;
		o_line_num <= n;
		o_line_start <= 1'b1;
		@(posedge i_clk);
		o_line_start <= 1'b0;
	endtask : send_line

	task automatic end_line(input attr_packet_pkg::video_std_t s);
		@(posedge i_clk);
		o_std <= s;
		o_line_end <= 1'b1;
		@(posedge i_clk);
		o_line_end <= 1'b0;
	endtask : end_line
endmodule : video_sink_model

// ===== tb/tb.sv
// self-checking bench for the attribute packet inserter
`timescale 1ns/1ps
`include "attr_packet_regs.svh"

module tb;
	logic                        i_clk;
	logic                        i_reset;
	logic [`AP_ADDR_W-1:0]       i_addr;
	logic [31:0]                 i_wdata;
	logic                        i_wr;
	logic                        i_rd;
	logic [31:0]                 o_rdata;
	attr_packet_pkg::video_std_t v_std;
	logic                        v_start;
	logic [10:0]                 v_num;
	logic                        v_end;
	logic                        o_line_stall;
	attr_packet_pkg::dac_trio_t  i_dac;
	attr_packet_pkg::dac_trio_t  o_dac;
	attr_packet_pkg::pkt_bit_t   o_pkt;
	logic [133:0]                exp_pkt;
	int                          num_errors = 0;
	int                          n_compared = 0;

	attr_packet_inserter i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_std(v_std),
		.i_line_start(v_start), .i_line_num(v_num), .i_line_end(v_end),
		.o_line_stall(o_line_stall), .i_dac(i_dac), .o_dac(o_dac), .o_pkt(o_pkt));

	video_sink_model model (.i_clk(i_clk), .i_pkt(o_pkt), .o_std(v_std),
		.o_line_start(v_start), .o_line_num(v_num), .o_line_end(v_end));

	task automatic check(input logic [133:0] seen, input logic [133:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test;
		$display("errors %0d compares %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		check(o_rdata, exp);
	endtask : rd_chk

	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	// generous bound: whole run is under two thousand cycles
	initial begin
		#200000;
		num_errors++;
		finish_test();
	end

	initial begin
		automatic attr_packet_pkg::video_std_t stds[7] = '{attr_packet_pkg::STD_525P,
			attr_packet_pkg::STD_1080I, attr_packet_pkg::STD_1080I, attr_packet_pkg::STD_720P,
			attr_packet_pkg::STD_525P, attr_packet_pkg::STD_OTHER, attr_packet_pkg::STD_720P};
		automatic logic [10:0] lines[7] = '{11'd40, 11'd18, 11'd581, 11'd23, 11'd41, 11'd40, 11'd40};
		automatic logic [15:0] pw;
		automatic int n0;
		automatic int sc;
		i_reset = 1'b1;
		i_addr = '0;
		i_wdata = 32'h0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_dac = {10'h045, 10'h123, 10'h3FE};
		repeat (12) @(posedge i_clk);
		i_reset <= 1'b0;
		rd_chk(`AP_OFS_HDR, 32'h0); // header reset
		rd_chk(`AP_OFS_DAC, 32'h0000FE00); // offset reset
		rd_chk(`AP_OFS_EXT, 32'h0); // count reset
		rd_chk(`AP_OFS_FULLSW, 32'h0); // normal at reset
		wr(8'h3C, 32'hFFFFFFFF);
		rd_chk(8'h3C, 32'h0); // hole reads zero
		check(o_dac, 30'h0); // no output while gated
		wr(`AP_OFS_CLKCTL, 32'h1);
		repeat (3) @(posedge i_clk);
		check(o_dac, {10'h045, 10'h123, 10'h3FE}); // pass-through
		wr(`AP_OFS_FULLSW, 32'h10);
		wr(`AP_OFS_DAC, 32'h1600);
		repeat (3) @(posedge i_clk);
		check(o_dac, {10'h045, 10'h123, 10'h3FF}); // saturated
		i_dac[0] <= 10'h100;
		repeat (3) @(posedge i_clk);
		check(o_dac, {10'h045, 10'h123, 10'h105}); // offset added
		wr(`AP_OFS_DAC, 32'h1500);
		repeat (3) @(posedge i_clk);
		check(o_dac, {10'h045, 10'h123, 10'h085}); // half gain
		wr(`AP_OFS_FULLSW, 32'h60);
		wr(`AP_OFS_DAC, 32'h0200);
		repeat (3) @(posedge i_clk);
		check(o_dac, {10'h045, 10'h123, 10'h100}); // unity gain on dac1 and dac2
		wr(`AP_OFS_DAC, 32'h1400);
		repeat (3) @(posedge i_clk);
		check(o_dac, {10'h005, 10'h005, 10'h100}); // offset alone at zero gain
		wr(`AP_OFS_FULLSW, 32'h0);
		wr(`AP_OFS_HDR, 32'hEA);
		rd_chk(`AP_OFS_HDR, 32'hAA); // reserved bit dropped
		exp_pkt = '0;
		exp_pkt[5:0] = 6'h2A;
		for (int i = 0; i < 8; i++) begin
			pw = 16'hC3A5 + 16'h1F0B * i;
			exp_pkt[6 + 16 * i +: 16] = pw;
			wr(`AP_OFS_PAY_FIRST + 8'(4 * i), {16'h0, pw});
		end
		rd_chk(`AP_OFS_PAY_LAST, {16'h0, exp_pkt[133:118]}); // last word
		for (int k = 0; k < 7; k++) begin
			n0 = model.n_pkts;
			model.send_line(stds[k], lines[k]);
			repeat (20) @(posedge i_clk);
			if (k == 0) begin
				rd_chk(`AP_OFS_STATUS, 32'h3); // running and busy
				wr(`AP_OFS_PAY_FIRST, 32'h0000BEEF);
			end
			repeat (140) @(posedge i_clk);
			check(model.n_pkts, n0 + (k < 4 ? 1 : 0)); // inserted on match only
			if (k < 4) begin
				check(model.cnt_q, 8'h86); // bit count
				check(model.lat_q, 8'h0A); // start latency
				check(model.bits_q, exp_pkt); // header then payload
			end
			if (k == 0) exp_pkt[21:6] = 16'hBEEF;
		end
		wr(`AP_OFS_HDR, 32'h2A);
		n0 = model.n_pkts;
		model.send_line(attr_packet_pkg::STD_525P, 11'd40);
		repeat (160) @(posedge i_clk);
		check(model.n_pkts, n0); // disabled inserts nothing
		for (int k = 0; k < 4; k++) begin
			wr(`AP_OFS_EXT, (k == 1) ? 32'h1 : (k == 3) ? 32'h0 : 32'h3);
			model.end_line(k == 1 ? attr_packet_pkg::STD_720P :
				k == 2 ? attr_packet_pkg::STD_525P : attr_packet_pkg::STD_1080I);
			sc = 0;
			repeat (12) begin
				#1;
				if (o_line_stall === 1'b1) sc++;
				@(posedge i_clk);
			end
			check(sc, (k == 0) ? 3 : (k == 1) ? 1 : 0); // stall length per mode
		end
		finish_test();
	end
endmodule : tb
